// ---- gpib_device_interface_parser.v ----
`timescale 1ns/1ps
`include "gpib_parser_consts.vh"

module gpib_device_interface_parser #(
  parameter COND_W = 6
) (
  // Clock and reset
  input wire CLK_SYS_I,
  input wire RST_I,
  // APB slave
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PWRITE_I,
  input wire [7:0] PADDR_I,
  input wire [31:0] PWDATA_I,
  output reg [31:0] PRDATA_O,
  output wire PREADY_O,
  output wire PSLVERR_O,
  // Instrument bus lines, active low as on the cable
  input wire ATN_N_I,
  input wire IFC_N_I,
  input wire REN_N_I,
  input wire DAV_N_I,
  input wire [7:0] DIO_N_I,
  output reg [7:0] DIO_N_O,
  output reg DIO_OE_O,
  output wire SRQ_N_O,
  output wire SRQ_OE_O,
  // Front panel
  input wire LOCAL_KEY_I,
  output reg KEYS_EN_O,
  output reg LOCAL_KEY_EN_O,
  output reg REMOTE_INDICATOR_O,
  output reg TALK_INDICATOR_O,
  output reg LISTEN_INDICATOR_O,
  output reg SRQ_INDICATOR_O,
  // Events to the instrument
  output reg TRIGGER_O,
  output reg DEV_CLEAR_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for pins
  reg [12:0] sync1_reg;
  reg [12:0] sync2_reg;
  reg dav_prev_reg;
  reg atn_prev_reg;
  wire atn = ~sync2_reg[0];
  wire ifc = ~sync2_reg[1];
  wire ren = ~sync2_reg[2];
  wire dav = ~sync2_reg[3];
  wire local_key = ~sync2_reg[4];
  wire [7:0] bus_byte = ~sync2_reg[12:5];
  reg local_prev_reg;

  always @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      sync1_reg <= 13'h1fff;
      sync2_reg <= 13'h1fff;
      dav_prev_reg <= 1'b0;
      atn_prev_reg <= 1'b0;
      local_prev_reg <= 1'b0;
    end else begin
      sync1_reg <= {DIO_N_I, ~LOCAL_KEY_I, DAV_N_I, REN_N_I, IFC_N_I, ATN_N_I};
      sync2_reg <= sync1_reg;
      dav_prev_reg <= dav;
      atn_prev_reg <= atn;
      local_prev_reg <= local_key;
    end
  end

  // Key bit is kept inverted; reset is the released level
  wire key_press = local_key & ~local_prev_reg;
  wire byte_strobe = dav & ~dav_prev_reg;
  wire cmd_strobe = byte_strobe & atn;

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  reg [4:0] addr_reg;
  reg trig_bus_reg;
  reg [COND_W-1:0] cond_reg;
  reg [COND_W-1:0] srq_mask_reg;
  reg [31:0] present_reg;
  reg [31:0] def_reg;
  reg [31:0] min_reg;
  reg [31:0] max_reg;
  reg [31:0] opt_word_reg;
  reg done_reg;
  reg [31:0] res_value_reg;
  reg [5:0] res_kind_reg;

  wire apb_wr = PSEL_I & PENABLE_I & PWRITE_I;
  wire apb_rd = PSEL_I & PENABLE_I & ~PWRITE_I;
  reg addr_ok;

  always @* begin
    case (PADDR_I)
      `OFS_CTRL, `OFS_STATUS, `OFS_COND, `OFS_SRQ_MASK, `OFS_CHAR, `OFS_RES_KIND,
      `OFS_RES_VALUE, `OFS_PRESENT, `OFS_DEF, `OFS_MIN, `OFS_MAX, `OFS_OPT_WORD: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // Zero wait state slave; unmapped offsets answer with an error
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~addr_ok;

  always @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      addr_reg <= `ADDR_RESET;
      trig_bus_reg <= 1'b0;
      cond_reg <= {COND_W{1'b0}};
      srq_mask_reg <= {COND_W{1'b0}};
      present_reg <= 32'h0000_0000;
      def_reg <= 32'h0000_0000;
      min_reg <= 32'h0000_0000;
      max_reg <= 32'h0000_0000;
      opt_word_reg <= 32'h0000_0000;
    end else if (apb_wr) begin
      case (PADDR_I)
        `OFS_CTRL: begin
          addr_reg <= PWDATA_I[`CTRL_ADDR_LSB+4:`CTRL_ADDR_LSB];
          trig_bus_reg <= PWDATA_I[`CTRL_TRIG_BUS_BIT];
        end
        `OFS_COND: cond_reg <= PWDATA_I[COND_W-1:0];
        `OFS_SRQ_MASK: srq_mask_reg <= PWDATA_I[COND_W-1:0];
        `OFS_PRESENT: present_reg <= PWDATA_I;
        `OFS_DEF: def_reg <= PWDATA_I;
        `OFS_MIN: min_reg <= PWDATA_I;
        `OFS_MAX: max_reg <= PWDATA_I;
        `OFS_OPT_WORD: opt_word_reg <= PWDATA_I;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interface state: addressing, remote, lockout, poll
  reg talk_reg;
  reg listen_reg;
  reg remote_reg;
  reg lockout_reg;
  reg spoll_reg;
  reg srq_reg;
  reg sent_stb_reg;
  wire my_listen = cmd_strobe & (bus_byte == {`LISTEN_BASE, addr_reg});
  wire my_talk = cmd_strobe & (bus_byte == {`TALK_BASE, addr_reg});
  wire other_talk = cmd_strobe & (bus_byte[7:5] == `TALK_BASE) & ~my_talk & (bus_byte != `CMD_UNT);
  wire dcl = cmd_strobe & (bus_byte == `CMD_DCL);
  wire sdc = cmd_strobe & (bus_byte == `CMD_SDC) & listen_reg;
  wire gtl = cmd_strobe & (bus_byte == `CMD_GTL) & listen_reg;
  wire dev_clear = dcl | sdc;
  wire [COND_W-1:0] cause = cond_reg & srq_mask_reg;
  wire [COND_W+5:0] cause_w = {6'h00, cause};
  wire [7:0] stb = {1'b0, srq_reg, cause_w[5:0]};
  // Poll byte counts as read once attention returns after it was driven
  wire poll_read = sent_stb_reg & atn & ~atn_prev_reg;
  reg cause_prev_reg;

  always @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      talk_reg <= 1'b0;
      listen_reg <= 1'b0;
      remote_reg <= 1'b0;
      lockout_reg <= 1'b0;
      spoll_reg <= 1'b0;
      srq_reg <= 1'b0;
      sent_stb_reg <= 1'b0;
      cause_prev_reg <= 1'b0;
    end else begin
      cause_prev_reg <= |cause;
      if (ifc) begin
        talk_reg <= 1'b0;
        listen_reg <= 1'b0;
        spoll_reg <= 1'b0;
      end else begin
        if (my_talk)
          talk_reg <= 1'b1;
        else if (my_listen || other_talk || (cmd_strobe && bus_byte == `CMD_UNT))
          talk_reg <= 1'b0;
        if (my_listen)
          listen_reg <= 1'b1;
        else if (my_talk || (cmd_strobe && bus_byte == `CMD_UNL))
          listen_reg <= 1'b0;
        if (cmd_strobe && bus_byte == `CMD_SPE)
          spoll_reg <= 1'b1;
        else if (cmd_strobe && bus_byte == `CMD_SPD)
          spoll_reg <= 1'b0;
      end
      // Remote enable dropping always returns to local and frees lockout
      if (!ren) begin
        remote_reg <= 1'b0;
        lockout_reg <= 1'b0;
      end else begin
        if (my_listen)
          remote_reg <= 1'b1;
        else if (gtl)
          remote_reg <= 1'b0;
        else if (key_press && !lockout_reg)
          remote_reg <= 1'b0;
        if (cmd_strobe && bus_byte == `CMD_LLO)
          lockout_reg <= 1'b1;
        else if (gtl)
          lockout_reg <= 1'b0;
      end
      // New cause wins over a poll read in the same cycle
      if ((|cause) && !cause_prev_reg)
        srq_reg <= 1'b1;
      else if (poll_read || !(|cause))
        srq_reg <= 1'b0;
      if (atn || !talk_reg || !spoll_reg)
        sent_stb_reg <= 1'b0;
      else
        sent_stb_reg <= 1'b1;
    end
  end

  assign SRQ_N_O = 1'b0;
  assign SRQ_OE_O = srq_reg;

  always @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      DIO_N_O <= 8'hff;
      DIO_OE_O <= 1'b0;
      KEYS_EN_O <= 1'b1;
      LOCAL_KEY_EN_O <= 1'b1;
      REMOTE_INDICATOR_O <= 1'b0;
      TALK_INDICATOR_O <= 1'b0;
      LISTEN_INDICATOR_O <= 1'b0;
      SRQ_INDICATOR_O <= 1'b0;
      TRIGGER_O <= 1'b0;
      DEV_CLEAR_O <= 1'b0;
    end else begin
      DIO_OE_O <= talk_reg & spoll_reg & ~atn;
      DIO_N_O <= ~stb;
      KEYS_EN_O <= ~remote_reg & ~lockout_reg;
      LOCAL_KEY_EN_O <= ~lockout_reg;
      REMOTE_INDICATOR_O <= remote_reg;
      TALK_INDICATOR_O <= talk_reg;
      LISTEN_INDICATOR_O <= listen_reg;
      SRQ_INDICATOR_O <= srq_reg;
      TRIGGER_O <= cmd_strobe & (bus_byte == `CMD_GET) & listen_reg & trig_bus_reg;
      DEV_CLEAR_O <= dev_clear;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command text parser; listener data takes priority over software chars
  localparam P_HDR = 4'b0001;
  localparam P_SEP = 4'b0010;
  localparam P_PAR = 4'b0100;
  localparam P_ERR = 4'b1000;

  wire bus_char = byte_strobe & ~atn & listen_reg;
  wire char_in = bus_char | (apb_wr & (PADDR_I == `OFS_CHAR));
  wire [7:0] raw = bus_char ? bus_byte : PWDATA_I[7:0];
  wire [7:0] ch = (raw >= 8'h61 && raw <= 8'h7a) ? raw - 8'h20 : raw;
  wire is_digit = (ch >= 8'h30) && (ch <= 8'h39);
  wire is_alpha = (ch >= 8'h41) && (ch <= 8'h5a);

  reg [3:0] state_reg;
  reg [31:0] word_reg;
  reg [2:0] wlen_reg;
  reg [31:0] hash_reg;
  reg query_reg;
  reg ndn_reg;
  reg [4:0] radix_reg;
  reg [31:0] num_reg;
  reg [23:0] pword_reg;
  reg [1:0] plen_reg;
  reg [31:0] hash_done_reg;
  reg [3:0] dval;
  reg dval_ok;

  // Optional word dropped from the hash, so both forms match alike
  wire [31:0] hash_word = (word_reg == opt_word_reg || wlen_reg == 3'h0) ? hash_reg :
                          ({hash_reg[26:0], hash_reg[31:27]} ^ word_reg);

  always @* begin
    dval = 4'h0;
    dval_ok = 1'b0;
    if (is_digit) begin
      dval = ch[3:0];
      dval_ok = (ch[3:0] < radix_reg[3:0]) | (radix_reg == 5'h10) | (radix_reg == 5'h0a);
      if (ch[3:0] > 4'h9)
        dval_ok = 1'b0;
    end else if (radix_reg == 5'h10 && ch >= 8'h41 && ch <= 8'h46) begin
      dval = ch[3:0] + 4'h9;
      dval_ok = 1'b1;
    end
    if (radix_reg == 5'h02 && dval > 4'h1)
      dval_ok = 1'b0;
    if (radix_reg == 5'h08 && dval > 4'h7)
      dval_ok = 1'b0;
  end

  reg [2:0] kind;
  reg [31:0] value;

  always @* begin
    kind = `KIND_NONE;
    value = query_reg ? present_reg : 32'h0000_0000;
    if (state_reg == P_ERR) begin
      kind = `KIND_ERR;
    end else if (state_reg == P_PAR) begin
      if (ndn_reg) begin
        kind = `KIND_NDN;
        value = num_reg;
      end else if (plen_reg == 2'h0) begin
        kind = `KIND_DEC;
        value = num_reg;
      end else if (pword_reg == 24'h4f4e00) begin
        kind = `KIND_BOOL;
        value = 32'h0000_0001;
      end else if (pword_reg == 24'h4f4646) begin
        kind = `KIND_BOOL;
        value = 32'h0000_0000;
      end else if (pword_reg == 24'h444546) begin
        kind = `KIND_DEF;
        value = def_reg;
      end else if (pword_reg == 24'h4d494e) begin
        kind = `KIND_MIN;
        value = min_reg;
      end else if (pword_reg == 24'h4d4158) begin
        kind = `KIND_MAX;
        value = max_reg;
      end else begin
        kind = `KIND_ERR;
      end
    end
  end

  wire clr_done = apb_wr & (PADDR_I == `OFS_STATUS) & PWDATA_I[`STATUS_DONE_BIT];
  wire finish = char_in & (ch == `CH_LF);

  always @(posedge CLK_SYS_I) begin
    if (RST_I || dev_clear) begin
      done_reg <= 1'b0;
      res_kind_reg <= 6'h00;
      res_value_reg <= 32'h0000_0000;
      hash_done_reg <= 32'h0000_0000;
    end else begin
      if (finish)
        done_reg <= 1'b1;
      else if (clr_done)
        done_reg <= 1'b0;
      if (finish) begin
        res_kind_reg <= {value == 32'h0000_0000 ? 1'b0 : 1'b1, query_reg, 1'b0, kind};
        res_value_reg <= value;
        hash_done_reg <= (state_reg == P_HDR) ? hash_word : hash_reg;
      end
    end
  end

  always @(posedge CLK_SYS_I) begin
    if (RST_I || dev_clear || finish) begin
      state_reg <= P_HDR;
      word_reg <= 32'h0000_0000;
      wlen_reg <= 3'h0;
      hash_reg <= 32'h0000_0000;
      query_reg <= 1'b0;
      ndn_reg <= 1'b0;
      radix_reg <= 5'h0a;
      num_reg <= 32'h0000_0000;
      pword_reg <= 24'h000000;
      plen_reg <= 2'h0;
    end else begin
      if (char_in) begin
        case (state_reg)
          P_HDR: begin
            if (ch == `CH_COLON || ch == `CH_SPACE) begin
              hash_reg <= hash_word;
              word_reg <= 32'h0000_0000;
              wlen_reg <= 3'h0;
              if (ch == `CH_SPACE)
                state_reg <= P_SEP;
            end else if (ch == `CH_QUERY) begin
              query_reg <= 1'b1;
            end else if (is_alpha || is_digit || ch == 8'h2a) begin
              if (wlen_reg < 3'h4) begin
                word_reg <= {word_reg[23:0], ch};
                wlen_reg <= wlen_reg + 3'h1;
              end
            end else begin
              state_reg <= P_ERR;
            end
          end
          P_SEP, P_PAR: begin
            if (ch == `CH_SPACE) begin
              state_reg <= state_reg;
            end else if (ch == `CH_HASH && state_reg == P_SEP) begin
              ndn_reg <= 1'b1;
              radix_reg <= 5'h00;
              state_reg <= P_PAR;
            end else if (ndn_reg && radix_reg == 5'h00) begin
              if (ch == 8'h42)
                radix_reg <= 5'h02;
              else if (ch == 8'h48)
                radix_reg <= 5'h10;
              else if (ch == 8'h51)
                radix_reg <= 5'h08;
              else
                state_reg <= P_ERR;
            end else if (dval_ok && plen_reg == 2'h0) begin
              num_reg <= num_reg * {27'h0, radix_reg} + {28'h0, dval};
              state_reg <= P_PAR;
            end else if (is_alpha && !ndn_reg) begin
              if (plen_reg < 2'h3) begin
                pword_reg <= pword_reg | ({16'h0000, ch} << (5'd16 - {plen_reg, 3'b000}));
                plen_reg <= plen_reg + 2'h1;
              end
              state_reg <= P_PAR;
            end else begin
              state_reg <= P_ERR;
            end
          end
          P_ERR: state_reg <= P_ERR;
          default: state_reg <= P_HDR;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  always @* begin
    PRDATA_O = 32'h0000_0000;
    if (apb_rd) begin
      case (PADDR_I)
        `OFS_CTRL: PRDATA_O = {23'h0, trig_bus_reg, 3'h0, addr_reg};
        `OFS_STATUS: PRDATA_O = {23'h0, done_reg, 1'b0, state_reg[3], spoll_reg, srq_reg, lockout_reg, remote_reg,
                                 listen_reg, talk_reg};
        `OFS_COND: PRDATA_O = {{(32-COND_W){1'b0}}, cond_reg};
        `OFS_SRQ_MASK: PRDATA_O = {{(32-COND_W){1'b0}}, srq_mask_reg};
        `OFS_CHAR: PRDATA_O = hash_done_reg;
        `OFS_RES_KIND: PRDATA_O = {26'h0, res_kind_reg};
        `OFS_RES_VALUE: PRDATA_O = res_value_reg;
        `OFS_PRESENT: PRDATA_O = present_reg;
        `OFS_DEF: PRDATA_O = def_reg;
        `OFS_MIN: PRDATA_O = min_reg;
        `OFS_MAX: PRDATA_O = max_reg;
        `OFS_OPT_WORD: PRDATA_O = opt_word_reg;
        default: PRDATA_O = 32'h0000_0000;
      endcase
    end
  end

endmodule // gpib_device_interface_parser

// ---- gpib_parser_consts.vh ----
//////////////////////////////////////////////////////////////////////////////
// Contract
// - Interface clear idles talker and listener only; the logic also ends serial poll mode
// - Lockout disables panel and local key
// - Go-to-local returns to local, enables keys
// - Device clear empties input, output, blocking commands
// - Universal device clear acts in any address state
// - Selected device clear acts only when listening
// - Group trigger fires only with bus source
// - Serial poll always returns the status byte
// - Remote only when addressed to listen with enable
// - Talk address activates talker; untalk, listen, clear idle
// - Listen address activates listener; unlisten, talk, clear idle
// - Service request holds until polled or causes clear
// - Local key cancels remote unless locked out
// - Optional command word present or absent, same result
// - Boolean 0/OFF disables, 1/ON enables
// - Non-decimal parameters with binary, hex, octal headers
// - Named values map to default, minimum, maximum
// - Trailing question mark makes a query
// - Command words match regardless of letter case
//////////////////////////////////////////////////////////////////////////////
`ifndef GPIB_PARSER_CONSTS_VH
`define GPIB_PARSER_CONSTS_VH

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_COND 8'h08
`define OFS_SRQ_MASK 8'h0c
`define OFS_CHAR 8'h10
`define OFS_RES_KIND 8'h14
`define OFS_RES_VALUE 8'h18
`define OFS_PRESENT 8'h1c
`define OFS_DEF 8'h20
`define OFS_MIN 8'h24
`define OFS_MAX 8'h28
`define OFS_OPT_WORD 8'h2c

// Control fields and reset values
`define CTRL_ADDR_LSB 0
`define CTRL_TRIG_BUS_BIT 8
`define ADDR_RESET 5'h0e
`define STATUS_DONE_BIT 8

// Bus command bytes (true logic)
`define CMD_GTL 8'h01
`define CMD_SDC 8'h04
`define CMD_GET 8'h08
`define CMD_LLO 8'h11
`define CMD_DCL 8'h14
`define CMD_SPE 8'h18
`define CMD_SPD 8'h19
`define CMD_UNL 8'h3f
`define CMD_UNT 8'h5f
`define LISTEN_BASE 3'h1
`define TALK_BASE 3'h2

// Parser characters
`define CH_LF 8'h0a
`define CH_SPACE 8'h20
`define CH_HASH 8'h23
`define CH_COLON 8'h3a
`define CH_QUERY 8'h3f

// Result kinds
`define KIND_NONE 3'h0
`define KIND_BOOL 3'h1
`define KIND_DEC 3'h2
`define KIND_NDN 3'h3
`define KIND_DEF 3'h4
`define KIND_MIN 3'h5
`define KIND_MAX 3'h6
`define KIND_ERR 3'h7

// Interface clear minimum, controller side
`define IFC_MIN_NS 100000
`define CLK_PERIOD_NS 100

`endif

// ---- gpib_ctrl_model.sv ----
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Controller stand-in; released lines float high on the bus pull-ups
module gpib_ctrl_model (
  // Clock
  input wire logic clk_i,
  // Bus lines, active low
  output logic atn_n_o,
  output logic ifc_n_o,
  output logic ren_n_o,
  output logic dav_n_o,
  output logic [7:0] dio_n_o
);
  initial begin
    atn_n_o = 1'b1;
    ifc_n_o = 1'b1;
    ren_n_o = 1'b1;
    dav_n_o = 1'b1;
    dio_n_o = 8'hff;
  end

  // No device handshake, so data is held well past the take
  task put(input logic cmd, input logic [7:0] b);
    atn_n_o <= !cmd;
    dio_n_o <= ~b;
    @(posedge clk_i);
    dav_n_o <= 1'b0;
    repeat (5) @(posedge clk_i);
    dav_n_o <= 1'b1;
    dio_n_o <= 8'hff;
    repeat (4) @(posedge clk_i);
  endtask

  task atn(input logic on);
    atn_n_o <= !on;
    @(posedge clk_i);
  endtask

  task ren(input logic on);
    ren_n_o <= !on;
    @(posedge clk_i);
  endtask

  task ifc;
    ifc_n_o <= 1'b0;
    repeat (1000) @(posedge clk_i);
    ifc_n_o <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask
endmodule // gpib_ctrl_model

// ---- gpib_checker.sv ----
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module gpib_checker (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  // Bus and panel inputs
  input wire logic IFC_N_I,
  input wire logic REN_N_I,
  input wire logic LOCAL_KEY_I,
  // Watched outputs
  input wire logic [7:0] DIO_N_O,
  input wire logic DIO_OE_O,
  input wire logic SRQ_OE_O,
  input wire logic KEYS_EN_O,
  input wire logic LOCAL_KEY_EN_O,
  input wire logic REMOTE_INDICATOR_O,
  input wire logic TALK_INDICATOR_O,
  input wire logic LISTEN_INDICATOR_O,
  input wire logic SRQ_INDICATOR_O,
  input wire logic TRIGGER_O,
  input wire logic DEV_CLEAR_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);

  //////////////////////////////////////////////////////////////////////////////
  // Sync stages delay the pins by a few edges
  sequence ifc_held;
    !IFC_N_I [*6];
  endsequence
  sequence free_press;
    $rose(LOCAL_KEY_I) && LOCAL_KEY_EN_O && REMOTE_INDICATOR_O;
  endsequence
  sequence locked_press;
    $rose(LOCAL_KEY_I) && !LOCAL_KEY_EN_O && REMOTE_INDICATOR_O && !REN_N_I;
  endsequence

  ifc_idles_a: assert property (ifc_held |-> !TALK_INDICATOR_O && !LISTEN_INDICATOR_O)
    else $error("addressed after clear");
  addr_excl_a: assert property (!(TALK_INDICATOR_O && LISTEN_INDICATOR_O))
    else $error("talker and listener both");
  remote_entry_a: assert property ($rose(REMOTE_INDICATOR_O) |-> LISTEN_INDICATOR_O && !REN_N_I)
    else $error("bad remote entry");
  remote_keys_a: assert property (REMOTE_INDICATOR_O && $past(REMOTE_INDICATOR_O) |-> !KEYS_EN_O)
    else $error("keys enabled in remote");
  lockout_keys_a: assert property (!LOCAL_KEY_EN_O && !$past(LOCAL_KEY_EN_O) |-> !KEYS_EN_O)
    else $error("keys enabled under lockout");
  locked_key_a: assert property (locked_press |=> REMOTE_INDICATOR_O [*6])
    else $error("local key acted under lockout");
  local_key_a: assert property (free_press |-> ##[1:8] !REMOTE_INDICATOR_O)
    else $error("local key ignored");
  trig_pulse_a: assert property (TRIGGER_O |-> LISTEN_INDICATOR_O ##1 !TRIGGER_O)
    else $error("bad trigger pulse");
  clear_pulse_a: assert property (DEV_CLEAR_O |=> !DEV_CLEAR_O)
    else $error("clear pulse too long");
  srq_lamp_a: assert property ($rose(SRQ_OE_O) |-> ##[0:2] SRQ_INDICATOR_O)
    else $error("no request lamp");
  poll_talker_a: assert property (DIO_OE_O |-> TALK_INDICATOR_O && DIO_N_O[7])
    else $error("poll byte driven badly");
endmodule // gpib_checker

bind gpib_device_interface_parser gpib_checker chk_u (
  .CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .IFC_N_I(IFC_N_I), .REN_N_I(REN_N_I), .LOCAL_KEY_I(LOCAL_KEY_I),
  .DIO_N_O(DIO_N_O), .DIO_OE_O(DIO_OE_O), .SRQ_OE_O(SRQ_OE_O), .KEYS_EN_O(KEYS_EN_O),
  .LOCAL_KEY_EN_O(LOCAL_KEY_EN_O), .REMOTE_INDICATOR_O(REMOTE_INDICATOR_O), .TALK_INDICATOR_O(TALK_INDICATOR_O),
  .LISTEN_INDICATOR_O(LISTEN_INDICATOR_O), .SRQ_INDICATOR_O(SRQ_INDICATOR_O), .TRIGGER_O(TRIGGER_O),
  .DEV_CLEAR_O(DEV_CLEAR_O));

// ---- gpib_device_interface_parser_tb.sv ----
`timescale 1ns/1ps
`include "gpib_parser_consts.vh"
//////////////////////////////////////////////////////////////////////////////
module gpib_device_interface_parser_tb;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, key = 1'b0, perr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rd, dv, mn, mx, pv, h;
  logic [4:0] a;
  logic [5:0] c;
  logic [7:0] b, mla, mta;
  wire [7:0] dio_no, m_dio, dio_w;
  wire [31:0] prdata;
  wire pready, pslverr, dio_oe, srq_oe, keys_en, lkey_en, remote_indicator, talk, listen_indicator, srq_ind, trig, dclr;
  wire atn_n, ifc_n, ren_n, dav_n;
  int errors = 0, comparisons = 0, clr_cnt = 0, trig_cnt = 0, n0;

  // Open-collector lines: either side pulls low
  assign dio_w = m_dio & (dio_oe ? dio_no : 8'hff);

  initial forever #50 clk = ~clk;
  always @(posedge clk) begin
    if (dclr === 1'b1) clr_cnt++;
    if (trig === 1'b1) trig_cnt++;
  end

  gpib_device_interface_parser dut_u (
    .CLK_SYS_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .ATN_N_I(atn_n),
    .IFC_N_I(ifc_n), .REN_N_I(ren_n), .DAV_N_I(dav_n), .DIO_N_I(dio_w), .DIO_N_O(dio_no), .DIO_OE_O(dio_oe),
    .SRQ_N_O(), .SRQ_OE_O(srq_oe), .LOCAL_KEY_I(key), .KEYS_EN_O(keys_en), .LOCAL_KEY_EN_O(lkey_en),
    .REMOTE_INDICATOR_O(remote_indicator), .TALK_INDICATOR_O(talk), .LISTEN_INDICATOR_O(listen_indicator), .SRQ_INDICATOR_O(srq_ind),
    .TRIGGER_O(trig), .DEV_CLEAR_O(dclr));
  gpib_ctrl_model bus_u (.clk_i(clk), .atn_n_o(atn_n), .ifc_n_o(ifc_n), .ren_n_o(ren_n), .dav_n_o(dav_n),
    .dio_n_o(m_dio));

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [5:0] kexp(input logic [2:0] k, input logic q, input logic [31:0] v);
    return {v != 0, q, 1'b0, k};
  endfunction
  function automatic logic [7:0] pbyte(input logic s, input logic [5:0] cc, input logic [5:0] m);
    return {1'b0, s, cc & m};
  endfunction

  task summarize;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task hang;
    errors++;
    $display("CHECK FAILED %0t wait ran out", $time);
    summarize;
  endtask
  task chk(input logic [32:0] got, input logic [32:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) hang;
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // One space between header and parameter
  task automatic send(input string s);
    int n;
    for (n = 0; n < s.len(); n++) apb(1'b1, `OFS_CHAR, {24'h0, s[n]});
    apb(1'b1, `OFS_CHAR, {24'h0, `CH_LF});
    n = 0;
    do begin
      apb(1'b0, `OFS_STATUS, 32'h0);
      n++;
    end while (rd[`STATUS_DONE_BIT] !== 1'b1 && n < 20);
    if (rd[`STATUS_DONE_BIT] !== 1'b1) hang;
    apb(1'b1, `OFS_STATUS, 32'h100);
  endtask
  task automatic prs(input string s, input logic [2:0] k, input logic q, input logic [31:0] v, input logic ckv);
    send(s);
    apb(1'b0, `OFS_RES_KIND, 32'h0);
    chk(rd[5:0], kexp(k, q, v), s);
    apb(1'b0, `OFS_RES_VALUE, 32'h0);
    if (ckv) chk(rd, v, s);
  endtask

  task bcmd(input logic [7:0] v);
    bus_u.put(1'b1, v);
  endtask
  task key_press;
    key <= 1'b1;
    repeat (6) @(posedge clk);
    key <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic poll(output logic [7:0] pb);
    int n;
    bcmd(mta);
    bcmd(`CMD_SPE);
    bus_u.atn(1'b0);
    for (n = 0; n < 30 && dio_oe !== 1'b1; n++) @(posedge clk);
    if (dio_oe !== 1'b1) hang;
    pb = ~dio_no;
    bus_u.atn(1'b1);
    repeat (5) @(posedge clk);
    bcmd(`CMD_SPD);
    bcmd(`CMD_UNT);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(91650));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    a = 5'($urandom % 31);
    c = 6'($urandom | 1);
    mla = {`LISTEN_BASE, a};
    mta = {`TALK_BASE, a};
    apb(1'b0, `OFS_CTRL, 32'h0);
    chk(rd[8:0], {4'h0, `ADDR_RESET}, "ctrl reset");
    apb(1'b0, 8'h40, 32'h0);
    chk({perr, rd}, {1'b1, 32'h0}, "unmapped read");
    apb(1'b1, `OFS_CTRL, {27'h0, a});
    bus_u.ren(1'b1);
    bcmd(mla);
    chk({listen_indicator, remote_indicator, keys_en}, 3'b110, "listen address");
    bcmd(mta);
    chk({talk, listen_indicator}, 2'b10, "talk address");
    bcmd(mla);
    chk({talk, listen_indicator}, 2'b01, "listen idles talker");
    bcmd(`CMD_UNL);
    chk(listen_indicator, 1'b0, "unlisten");
    bcmd(mta);
    bcmd(`CMD_UNT);
    chk(talk, 1'b0, "untalk");
    key_press;
    chk({remote_indicator, keys_en}, 2'b01, "local key");
    bcmd(mla);
    bcmd(`CMD_LLO);
    chk({remote_indicator, keys_en, lkey_en}, 3'b100, "lockout");
    key_press;
    chk(remote_indicator, 1'b1, "key under lockout");
    bcmd(`CMD_GTL);
    chk({remote_indicator, keys_en, lkey_en}, 3'b011, "go to local");
    bcmd(`CMD_UNL);
    n0 = clr_cnt;
    bcmd(`CMD_SDC);
    chk(clr_cnt, n0, "clear unaddressed");
    bcmd(`CMD_DCL);
    chk(clr_cnt, n0 + 1, "universal clear");
    bcmd(mla);
    bcmd(`CMD_SDC);
    chk(clr_cnt, n0 + 2, "selected clear");
    n0 = trig_cnt;
    bcmd(`CMD_GET);
    chk(trig_cnt, n0, "trigger off");
    apb(1'b1, `OFS_CTRL, {23'h0, 1'b1, 3'h0, a});
    bcmd(`CMD_GET);
    chk(trig_cnt, n0 + 1, "trigger");
    bcmd(`CMD_UNL);
    bcmd(`CMD_GET);
    chk(trig_cnt, n0 + 1, "trigger unaddressed");
    apb(1'b1, `OFS_COND, {26'h0, c});
    apb(1'b1, `OFS_SRQ_MASK, 32'h0);
    poll(b);
    chk({srq_oe, b}, {1'b0, pbyte(1'b0, c, 6'h0)}, "quiet poll");
    apb(1'b1, `OFS_SRQ_MASK, {26'h0, c});
    repeat (3) @(posedge clk);
    chk({srq_oe, srq_ind}, 2'b11, "service request");
    poll(b);
    chk({srq_oe, b}, {1'b0, pbyte(1'b1, c, c)}, "request poll");
    bcmd(mta);
    bus_u.ifc;
    chk({talk, listen_indicator}, 2'b00, "interface clear");
    apb(1'b0, `OFS_COND, 32'h0);
    chk(rd[5:0], c, "settings kept");
    dv = ($urandom & 32'hffff) | 1;
    mn = ($urandom & 32'hffff) | 1;
    mx = ($urandom & 32'hffff) | 1;
    pv = ($urandom & 32'hffff) | 1;
    apb(1'b1, `OFS_DEF, dv);
    apb(1'b1, `OFS_MIN, mn);
    apb(1'b1, `OFS_MAX, mx);
    apb(1'b1, `OFS_PRESENT, pv);
    apb(1'b1, `OFS_OPT_WORD, 32'h00494d4d);
    prs("DISP:ENAB ON", `KIND_BOOL, 1'b0, 1, 1'b0);
    prs("disp:Enab off", `KIND_BOOL, 1'b0, 0, 1'b0);
    prs("DISP:ENAB 1", `KIND_DEC, 1'b0, 1, 1'b1);
    prs("DISP:ENAB 0", `KIND_DEC, 1'b0, 0, 1'b1);
    prs("*SRE #B10001", `KIND_NDN, 1'b0, 17, 1'b1);
    prs("*SRE #H1F", `KIND_NDN, 1'b0, 31, 1'b1);
    prs("*SRE #Q17", `KIND_NDN, 1'b0, 15, 1'b1);
    prs("ARM:TIM DEF", `KIND_DEF, 1'b0, dv, 1'b1);
    prs("ARM:TIM MIN", `KIND_MIN, 1'b0, mn, 1'b1);
    prs("ARM:TIM MAX", `KIND_MAX, 1'b0, mx, 1'b1);
    prs("ARM:TIM? MAX", `KIND_MAX, 1'b1, mx, 1'b1);
    send("arm:tim?");
    apb(1'b0, `OFS_RES_KIND, 32'h0);
    chk(rd[4], 1'b1, "query flag");
    apb(1'b0, `OFS_RES_VALUE, 32'h0);
    chk(rd, pv, "query value");
    send("INIT");
    apb(1'b0, `OFS_CHAR, 32'h0);
    h = rd;
    send("init:Imm");
    apb(1'b0, `OFS_CHAR, 32'h0);
    chk(rd, h, "optional word");
    summarize;
  end
endmodule // gpib_device_interface_parser_tb
